/* File: bsd_map.svh */
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH
// What this block does
// - full-scale selector forces bipolar, supply input, reports 3FFFh as FFFCh
// - rail-check enable with non-switch scan request appends zero and full-scale checks
// - quarter-scale selector loads threshold DAC with 3FFh and routes it
// - three-quarter selector loads threshold DAC with C00h and routes it
// - scan kind 100 short, 101 open, 110 odd wire, 111 even wire
// - host starts switch scans; device then applies overrides and alternate path
// - open and wire modes flag channel below low or above high threshold
// - short mode flags unipolar channel whose voltage is below short threshold
// - switch alert field clears when a switch-diagnostic scan request arrives
// - alert field written at scan complete, held until next switch request
// - summary bit at end of switch scan is OR of fourteen alerts
// - equal top cells mask alerts above top cell; differing masks none
// - summary clears when later scan resolves alerts or software writes zero
// - switch scans leave overvoltage, undervoltage and mismatch alerts unchanged
// - short mode: switches off, alternate path, enabled unipolar cells only
// - short overrides: aux enables zero, switches zero, selectors zero, path one
// - overrides apply only during the scan; normal settings restored after
`define BSD_NCH          14
`define BSD_SEL_FULL     4'hB
`define BSD_SEL_ZERO     4'hA
`define BSD_SEL_DACQ     4'h8
`define BSD_SEL_DAC3Q    4'h7
`define BSD_DAC_QTR      12'h3FF
`define BSD_DAC_3QTR     12'hC00
`define BSD_FULL_CODE    14'h3FFF
`define BSD_ZERO_CODE    14'h0000
`define BSD_ODD_SW       14'h1555
`define BSD_EVEN_SW      14'h2AAA
`define BSD_SCAN_SHORT   3'b100
`define BSD_SCAN_OPEN    3'b101
`define BSD_SCAN_ODD     3'b110
`define BSD_SCAN_EVEN    3'b111
`define BSD_OVS_ONE      3'h0
`define BSD_SEL_NONE     4'h0
`endif

/* File: bsd_pkg.sv */
package bsd_pkg;
  typedef enum logic [1:0] {
    BSD_IDLE = 2'b00,
    BSD_SCAN = 2'b01,
    BSD_RAIL = 2'b10
  } bsd_state_t;
endpackage : bsd_pkg

/* File: bsd_chan_cmp.sv */
`timescale 1ns/1ps
`include "bsd_map.svh"
module bsd_chan_cmp (
  input  wire logic        i_short_mode,
  input  wire logic [13:0] i_value,
  input  wire logic [13:0] i_short_thr,
  input  wire logic [13:0] i_low_thr,
  input  wire logic [13:0] i_high_thr,
  output logic             o_fault
);
  always_comb begin
    if (i_short_mode) begin
      o_fault = (i_value < i_short_thr);
    end else begin
      o_fault = (i_value < i_low_thr) || (i_value > i_high_thr);
    end
  end
endmodule : bsd_chan_cmp

/* File: bsd_diag.sv */
`timescale 1ns/1ps
`include "bsd_map.svh"
module bsd_diag #(
  parameter int NCH = `BSD_NCH
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic [2:0]        i_scan_kind_select,
  input  wire logic              i_scan_request,
  input  wire logic              i_conv_done,
  input  wire logic [3:0]        i_conv_channel,
  input  wire logic [13:0]       i_conv_value,
  input  wire logic              i_scan_end,
  input  wire logic              i_rail_done,
  input  wire logic              i_end_scan_rail_check_enable,
  input  wire logic [3:0]        i_diag_selector_first,
  input  wire logic [3:0]        i_diag_selector_second,
  input  wire logic [15:0]       i_cell_block_measure_enables,
  input  wire logic [5:0]        i_aux_measure_enables,
  input  wire logic [NCH-1:0]    i_switch_enable_mask,
  input  wire logic [2:0]        i_oversample_rate,
  input  wire logic              i_alternate_path_select,
  input  wire logic [NCH-1:0]    i_channel_bipolar_flag,
  input  wire logic [NCH-1:0]    i_cell_measure_enable,
  input  wire logic [3:0]        i_highest_cell_setting_a,
  input  wire logic [3:0]        i_highest_cell_setting_b,
  input  wire logic [13:0]       i_switch_short_threshold,
  input  wire logic [13:0]       i_switch_low_threshold,
  input  wire logic [13:0]       i_switch_high_threshold,
  input  wire logic              i_summary_clear,
  input  wire logic              i_ov_event,
  input  wire logic              i_uv_event,
  input  wire logic              i_mismatch_event,
  output logic                   o_scan_complete_flag,
  output logic                   o_diag_active,
  output logic                   o_rail_check_active,
  output logic [15:0]            o_eff_cell_block_measure_enables,
  output logic [5:0]             o_eff_aux_measure_enables,
  output logic [NCH-1:0]         o_eff_switch_enable_mask,
  output logic [3:0]             o_eff_diag_selector_first,
  output logic [3:0]             o_eff_diag_selector_second,
  output logic                   o_eff_alternate_path_select,
  output logic [2:0]             o_eff_oversample_rate,
  output logic                   o_force_bipolar,
  output logic                   o_route_analog_supply,
  output logic                   o_route_dac,
  output logic [11:0]            o_threshold_dac_code,
  output logic [15:0]            o_diag_result_word_first,
  output logic [15:0]            o_diag_result_word_second,
  output logic [NCH-1:0]         o_switch_fault_alerts,
  output logic                   o_switch_fault_summary,
  output logic                   o_overvoltage_alert,
  output logic                   o_undervoltage_alert,
  output logic                   o_cell_mismatch_alert
);
  import bsd_pkg::*;

  bsd_state_t     state_q, state_d;
  logic [2:0]     kind_q, kind_d;
  logic [NCH-1:0] pend_q, pend_d;
  logic [NCH-1:0] alert_q, alert_d;
  logic           sum_q, sum_d;
  logic           done_q, done_d;
  logic [2:0]     alarm_q, alarm_d;
  logic [15:0]    res1_q, res1_d, res2_q, res2_d;
  logic [NCH-1:0] fault;
  logic [NCH-1:0] topmask;
  logic [NCH-1:0] sw_mask;
  logic [15:0]    full_word;
  logic           sw_mode, active, req_sw;

  assign sw_mode = i_scan_kind_select[2];
  assign req_sw  = i_scan_request && sw_mode && (state_q == BSD_IDLE);
  assign active  = (state_q == BSD_SCAN) && kind_q[2];
  assign full_word = {`BSD_FULL_CODE, 2'b00};

  // one comparator per channel, all fed the same value; the conversion channel picks which alert is set
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_cmp
      bsd_chan_cmp u_cmp (
        .i_short_mode (kind_q == `BSD_SCAN_SHORT),
        .i_value      (i_conv_value),
        .i_short_thr  (i_switch_short_threshold),
        .i_low_thr    (i_switch_low_threshold),
        .i_high_thr   (i_switch_high_threshold),
        .o_fault      (fault[g])
      );
    end
  endgenerate

  // masking only applies when both top-cell settings agree
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      topmask[n] = (i_highest_cell_setting_a != i_highest_cell_setting_b)
                   || (n <= int'(i_highest_cell_setting_a));
    end
  end

  always_comb begin
    case (kind_q)
      `BSD_SCAN_ODD:  sw_mask = `BSD_ODD_SW & ~i_channel_bipolar_flag & topmask;
      `BSD_SCAN_EVEN: sw_mask = `BSD_EVEN_SW & ~i_channel_bipolar_flag & topmask;
      `BSD_SCAN_OPEN: sw_mask = i_switch_enable_mask;
      default:        sw_mask = '0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    pend_d  = pend_q;
    alert_d = alert_q;
    sum_d   = sum_q;
    done_d  = done_q;
    case (state_q)
      BSD_IDLE: begin
        if (i_scan_request) begin
          state_d = BSD_SCAN;
          kind_d  = i_scan_kind_select;
          done_d  = 1'b0;
          pend_d  = '0;
          if (sw_mode) begin
            alert_d = '0;
          end
        end
      end
      BSD_SCAN: begin
        if (kind_q[2] && i_conv_done && (i_conv_channel < 4'(NCH))) begin
          pend_d[i_conv_channel] = fault[i_conv_channel]
                                   && topmask[i_conv_channel];
        end
        if (i_scan_end) begin
          if (!kind_q[2] && i_end_scan_rail_check_enable) begin
            state_d = BSD_RAIL;
          end else begin
            state_d = BSD_IDLE;
            done_d  = 1'b1;
            if (kind_q[2]) begin
              alert_d = pend_d;
              sum_d   = |pend_d;
            end
          end
        end
      end
      BSD_RAIL: begin
        if (i_rail_done) begin
          state_d = BSD_IDLE;
          done_d  = 1'b1;
        end
      end
      default: state_d = BSD_IDLE;
    endcase
    // hardware setting at end of scan wins over a software clear
    if (i_summary_clear && !(done_d && !done_q && kind_q[2] && |pend_d)) begin
      sum_d = 1'b0;
    end
  end

  always_comb begin
    alarm_d = alarm_q;
    if (!active) begin
      alarm_d = alarm_q | {i_mismatch_event, i_uv_event, i_ov_event};
    end
  end

  always_comb begin
    res1_d = res1_q;
    res2_d = res2_q;
    // effective selectors, so a switch scan cannot overwrite the result word
    if (i_conv_done && (o_eff_diag_selector_first == `BSD_SEL_FULL)) begin
      res1_d = full_word;
    end
    if (i_conv_done && (o_eff_diag_selector_second == `BSD_SEL_FULL)) begin
      res2_d = full_word;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= BSD_IDLE;
      kind_q  <= 3'b000;
      pend_q  <= '0;
      alert_q <= '0;
      sum_q   <= 1'b0;
      done_q  <= 1'b0;
      alarm_q <= 3'b000;
      res1_q  <= 16'h0000;
      res2_q  <= 16'h0000;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      pend_q  <= pend_d;
      alert_q <= alert_d;
      sum_q   <= sum_d;
      done_q  <= done_d;
      alarm_q <= alarm_d;
      res1_q  <= res1_d;
      res2_q  <= res2_d;
    end
  end

  // overrides are combinational so they drop the cycle the scan ends
  always_comb begin
    o_eff_cell_block_measure_enables = i_cell_block_measure_enables;
    o_eff_aux_measure_enables        = i_aux_measure_enables;
    o_eff_switch_enable_mask         = i_switch_enable_mask;
    o_eff_diag_selector_first        = i_diag_selector_first;
    o_eff_diag_selector_second       = i_diag_selector_second;
    o_eff_alternate_path_select      = i_alternate_path_select;
    o_eff_oversample_rate            = i_oversample_rate;
    if (active) begin
      o_eff_cell_block_measure_enables[15:14] = 2'b00;
      o_eff_aux_measure_enables  = '0;
      o_eff_diag_selector_first  = `BSD_SEL_NONE;
      o_eff_diag_selector_second = `BSD_SEL_NONE;
      o_eff_alternate_path_select = 1'b1;
      o_eff_oversample_rate      = `BSD_OVS_ONE;
      o_eff_switch_enable_mask   = sw_mask;
      if (kind_q == `BSD_SCAN_SHORT) begin
        o_eff_cell_block_measure_enables[NCH-1:0] =
          i_cell_measure_enable & ~i_channel_bipolar_flag;
      end else begin
        o_eff_cell_block_measure_enables[NCH-1:0] =
          sw_mask & ~i_channel_bipolar_flag;
      end
    end
  end

  always_comb begin
    o_force_bipolar       = active && (kind_q != `BSD_SCAN_SHORT);
    o_route_analog_supply = 1'b0;
    o_route_dac           = 1'b0;
    o_threshold_dac_code  = 12'h000;
    if ((o_eff_diag_selector_first == `BSD_SEL_FULL)
        || (o_eff_diag_selector_second == `BSD_SEL_FULL)
        || (state_q == BSD_RAIL)) begin
      o_force_bipolar       = 1'b1;
      o_route_analog_supply = 1'b1;
    end
    if ((o_eff_diag_selector_first == `BSD_SEL_DACQ)
        || (o_eff_diag_selector_second == `BSD_SEL_DACQ)) begin
      o_route_dac          = 1'b1;
      o_threshold_dac_code = `BSD_DAC_QTR;
    end else if ((o_eff_diag_selector_first == `BSD_SEL_DAC3Q)
        || (o_eff_diag_selector_second == `BSD_SEL_DAC3Q)) begin
      o_route_dac          = 1'b1;
      o_threshold_dac_code = `BSD_DAC_3QTR;
    end
  end

  assign o_scan_complete_flag      = done_q;
  assign o_diag_active             = active;
  assign o_rail_check_active       = (state_q == BSD_RAIL);
  assign o_diag_result_word_first  = res1_q;
  assign o_diag_result_word_second = res2_q;
  assign o_switch_fault_alerts     = alert_q;
  assign o_switch_fault_summary    = sum_q;
  assign o_overvoltage_alert       = alarm_q[0];
  assign o_undervoltage_alert      = alarm_q[1];
  assign o_cell_mismatch_alert     = alarm_q[2];

  chk_alert_clear: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    req_sw |=> (alert_q == '0))
    else $error("alerts not cleared");
  chk_alert_hold: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == BSD_SCAN) && !i_scan_end |=> $stable(alert_q))
    else $error("alerts moved mid scan");
  chk_sum_or: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(done_q) && kind_q[2] |-> (sum_q == |alert_q))
    else $error("summary not or of alerts");
  chk_alarm_frozen: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    active |=> $stable(alarm_q))
    else $error("alarm changed");
  chk_path_override: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    active |-> o_eff_alternate_path_select
    && (o_eff_oversample_rate == `BSD_OVS_ONE))
    else $error("override missing");
  chk_short_off: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    active && (kind_q == `BSD_SCAN_SHORT) |-> (o_eff_switch_enable_mask == '0))
    else $error("switches on in short");
  chk_restore: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == BSD_IDLE) |-> (o_eff_switch_enable_mask == i_switch_enable_mask))
    else $error("override leaked");
  chk_rail_append: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == BSD_SCAN) && !kind_q[2] && i_scan_end
    && i_end_scan_rail_check_enable |=> o_rail_check_active)
    else $error("rail check skipped");
  chk_dac_quarter: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (o_eff_diag_selector_first == `BSD_SEL_DACQ) |-> o_route_dac
    && (o_threshold_dac_code == `BSD_DAC_QTR))
    else $error("dac quarter wrong");
  // a switch scan must silence every selector-driven diagnostic route
  chk_sel_cleared: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    active |-> (o_eff_diag_selector_first == `BSD_SEL_NONE)
    && (o_eff_diag_selector_second == `BSD_SEL_NONE) && !o_route_dac)
    else $error("selectors not cleared");
  chk_full_word: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_conv_done && (o_eff_diag_selector_first == `BSD_SEL_FULL)
    |=> (o_diag_result_word_first == {`BSD_FULL_CODE, 2'b00}))
    else $error("full scale word wrong");
endmodule : bsd_diag

/* File: bsd_diag_bench.sv */
`timescale 1ns/1ps
`include "bsd_map.svh"
module bsd_diag_bench;
  logic        clk = 1'b0, rst = 1'b1, req = 1'b0, cdone = 1'b0;
  logic        send = 1'b0, rdone = 1'b0, rail_en = 1'b0, alt = 1'b0;
  logic        sclr = 1'b0, ov = 1'b0, uv = 1'b0, mm = 1'b0;
  logic [2:0]  kind = 3'h0, ovs = 3'h3;
  logic [3:0]  cch = 4'h0, sel1 = 4'h0, sel2 = 4'h0;
  logic [3:0]  top_a = 4'h5, top_b = 4'h5;
  logic [5:0]  aux = 6'h3F;
  logic [13:0] cval = 14'h0, swm = 14'h3C3F, bip = 14'h0004;
  logic [13:0] cen = 14'h3FFF, thr_s = 14'h0A00;
  logic [13:0] thr_l = 14'h0100, thr_h = 14'h0800;
  logic [15:0] blk = 16'hFFFF;
  logic        flag, dact, ract, e_alt, fbip, rsup, rdac;
  logic        summ, ova, uva, mma;
  logic [2:0]  e_ovs;
  logic [3:0]  e_sel1, e_sel2;
  logic [5:0]  e_aux;
  logic [11:0] dac;
  logic [13:0] e_swm, alerts, dval;
  logic [15:0] e_blk, res1, res2;
  int          n_mismatch = 0, tests_run = 0;

  bsd_diag #(.NCH(`BSD_NCH)) dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_scan_kind_select(kind),
    .i_scan_request(req), .i_conv_done(cdone), .i_conv_channel(cch),
    .i_conv_value(cval), .i_scan_end(send), .i_rail_done(rdone),
    .i_end_scan_rail_check_enable(rail_en),
    .i_diag_selector_first(sel1), .i_diag_selector_second(sel2),
    .i_cell_block_measure_enables(blk), .i_aux_measure_enables(aux),
    .i_switch_enable_mask(swm), .i_oversample_rate(ovs),
    .i_alternate_path_select(alt), .i_channel_bipolar_flag(bip),
    .i_cell_measure_enable(cen), .i_highest_cell_setting_a(top_a),
    .i_highest_cell_setting_b(top_b), .i_switch_short_threshold(thr_s),
    .i_switch_low_threshold(thr_l), .i_switch_high_threshold(thr_h),
    .i_summary_clear(sclr), .i_ov_event(ov), .i_uv_event(uv),
    .i_mismatch_event(mm), .o_scan_complete_flag(flag),
    .o_diag_active(dact), .o_rail_check_active(ract),
    .o_eff_cell_block_measure_enables(e_blk),
    .o_eff_aux_measure_enables(e_aux), .o_eff_switch_enable_mask(e_swm),
    .o_eff_diag_selector_first(e_sel1),
    .o_eff_diag_selector_second(e_sel2),
    .o_eff_alternate_path_select(e_alt), .o_eff_oversample_rate(e_ovs),
    .o_force_bipolar(fbip), .o_route_analog_supply(rsup),
    .o_route_dac(rdac), .o_threshold_dac_code(dac),
    .o_diag_result_word_first(res1), .o_diag_result_word_second(res2),
    .o_switch_fault_alerts(alerts), .o_switch_fault_summary(summ),
    .o_overvoltage_alert(ova), .o_undervoltage_alert(uva),
    .o_cell_mismatch_alert(mma));

  always #25 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    tests_run++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic start(input logic [2:0] k);
    kind = k;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
  endtask : start

  // two cycles per result so the strobe is never raised twice in a step
  task automatic conv(input logic [3:0] ch, input logic [13:0] v);
    cch = ch;
    cval = v;
    cdone = 1'b1;
    @(negedge clk);
    cdone = 1'b0;
    @(negedge clk);
  endtask : conv

  task automatic pulse_end();
    send = 1'b1;
    @(negedge clk);
    send = 1'b0;
  endtask : pulse_end

  task automatic finish();
    pulse_end();
    for (int i = 0; i < 8 && flag !== 1'b1; i++) @(negedge clk);
    chk(16'(flag), 16'h1);
  endtask : finish

  initial begin
    #(50 * 4000);
    n_mismatch++;
    results();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk(16'({summ, alerts}), 16'h0);
    chk(e_blk, blk);
    sel1 = `BSD_SEL_FULL;
    sel2 = `BSD_SEL_FULL;
    @(negedge clk);
    chk(16'({fbip, rsup}), 16'h3);
    start(3'b000);
    conv(4'h0, 14'h0123);
    finish();
    chk(res1, 16'hFFFC);
    chk(res2, 16'hFFFC);
    sel2 = `BSD_SEL_DACQ;
    @(negedge clk);
    chk(16'({rdac, dac}), 16'h13FF);
    // nominal converter reading of the threshold DAC is its code times four
    dval = {dac, 2'b00};
    chk(16'(dval >= 14'h0F4D && dval <= 14'h1086), 16'h1);
    sel2 = `BSD_SEL_DAC3Q;
    @(negedge clk);
    chk(16'({rdac, dac}), 16'h1C00);
    dval = {dac, 2'b00};
    chk(16'(dval >= 14'h2F06 && dval <= 14'h30A4), 16'h1);
    $display("test selectors done");

    start(`BSD_SCAN_OPEN);
    chk(16'({dact, alerts}), 16'h4000);
    chk(e_blk, {2'b00, swm & ~bip});
    chk(16'(e_aux), 16'h0);
    chk(16'({e_sel1, e_sel2, e_alt, e_ovs}), 16'h0008);
    chk(16'({fbip, e_swm}), {2'b01, swm});
    conv(4'h0, 14'h0050);
    conv(4'h1, 14'h0400);
    {ov, uv, mm} = 3'b111;
    conv(4'h3, 14'h0900);
    {ov, uv, mm} = 3'b000;
    // channel 7 sits above the equal top cells, 14 is out of range
    conv(4'h7, 14'h0010);
    conv(4'hE, 14'h0000);
    finish();
    chk(16'(alerts), 16'h0009);
    chk(16'({summ, dact}), 16'h2);
    chk(16'({ova, uva, mma}), 16'h0);
    chk(e_blk, blk);
    chk(16'({e_sel1, e_alt, e_ovs}), 16'({sel1, alt, ovs}));
    start(`BSD_SCAN_OPEN);
    conv(4'h0, 14'h0400);
    finish();
    chk(16'({summ, alerts}), 16'h0);
    $display("test open done");

    top_b = 4'h6;
    start(`BSD_SCAN_SHORT);
    chk(16'(e_swm), 16'h0);
    chk(e_blk, {2'b00, cen & ~bip});
    chk(16'({e_sel1, e_sel2, e_alt, e_ovs}), 16'h0008);
    // selectors still hold full scale and 3/4 DAC; the scan must mute both
    chk(16'({fbip, rsup, rdac}), 16'h0);
    conv(4'hD, 14'h0500);
    conv(4'h4, 14'h0C00);
    // equal to the threshold is not below it
    conv(4'h6, 14'h0A00);
    finish();
    chk(16'({summ, alerts}), 16'h6000);
    $display("test short done");

    rail_en = 1'b1;
    start(3'b000);
    chk(16'(flag), 16'h0);
    {ov, uv, mm} = 3'b111;
    @(negedge clk);
    {ov, uv, mm} = 3'b000;
    pulse_end();
    chk(16'({ract, flag}), 16'h2);
    rdone = 1'b1;
    @(negedge clk);
    rdone = 1'b0;
    for (int i = 0; i < 8 && flag !== 1'b1; i++) @(negedge clk);
    chk(16'(flag), 16'h1);
    chk(16'({ova, uva, mma}), 16'h7);
    chk(16'(alerts), 16'h2000);
    rail_en = 1'b0;
    sclr = 1'b1;
    @(negedge clk);
    sclr = 1'b0;
    chk(16'(summ), 16'h0);
    $display("test rail done");

    for (int k = 0; k < 2; k++) begin
      start(k ? `BSD_SCAN_EVEN : `BSD_SCAN_ODD);
      chk(16'(e_swm), k ? 16'h2AAA : 16'h1551);
      conv(4'h1, 14'h0900);
      finish();
      chk(16'(alerts), 16'h0002);
    end
    $display("test wire done");
    results();
  end
endmodule : bsd_diag_bench
